// ==== motor_driver_host_registers.sv ====
/*
  Host register bank of a sensorless three-phase motor driver: speed
  command, nvm unlock and control, power control, status and rotor
  frequency readout.
  Assumes an i2c front end on i_core_clk that issues one-cycle byte
  read and write strobes; fault pins arrive asynchronously.
*/
`timescale 1ns/1ns
`include "motor_regs_defs.svh"

module motor_driver_host_registers
  import motor_regs_pkg::*;
(
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_clk_en,
  // register access from i2c front end
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  // speed command
  output logic      [8:0] o_speed_command_value,
  output logic            o_host_speed_select,
  // configuration and nvm
  output logic            o_config_wr,
  output logic            o_nvm_reload,
  output logic            o_nvm_program,
  // power control
  input  wire logic       i_sleep_request,
  input  wire logic       i_wake,
  output logic            o_low_power_enter,
  // fault pins
  input  wire logic       i_thermal_fault,
  input  wire logic       i_phase_overcurrent,
  input  wire logic       i_rotor_stall,
  // rotor frequency, tenths of hertz, same clock
  input  wire logic [15:0] i_rotor_frequency
);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  // ****************************************************************
  // access decode
  // ****************************************************************
  logic access;
  logic wr_low;
  logic wr_high;
  logic wr_key;
  logic wr_ctrl;
  logic rd_status;
  logic rd_freq_high;
  logic program_set;

  assign access       = i_clk_en && (i_reg_wr || i_reg_rd);
  assign wr_low       = i_clk_en && i_reg_wr && hits(i_reg_addr, `OFS_SPEED_COMMAND_LOW);
  assign wr_high      = i_clk_en && i_reg_wr && hits(i_reg_addr, `OFS_SPEED_COMMAND_HIGH_SELECT);
  assign wr_key       = i_clk_en && i_reg_wr && hits(i_reg_addr, `OFS_NVM_UNLOCK_KEY);
  assign wr_ctrl      = i_clk_en && i_reg_wr && hits(i_reg_addr, `OFS_NVM_AND_POWER_CONTROL);
  assign rd_status    = i_clk_en && i_reg_rd && hits(i_reg_addr, `OFS_FAULT_STATUS);
  assign rd_freq_high = i_clk_en && i_reg_rd && hits(i_reg_addr, `OFS_ROTOR_FREQUENCY_HIGH);
  assign program_set  = wr_ctrl && i_reg_wdata[`BIT_NVM_PROGRAM];

  // ****************************************************************
  // fault pin synchroniser
  // ****************************************************************
  logic [`SYNC_WIDTH-1:0] pins_sync;

  pin_sync u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_clk_en   (i_clk_en),
    .i_async    ({i_thermal_fault, i_phase_overcurrent, i_rotor_stall}),
    .o_sync     (pins_sync)
  );

  logic thermal_s;
  logic overcurrent_s;
  logic stall_s;

  assign thermal_s     = pins_sync[2];
  assign overcurrent_s = pins_sync[1];
  assign stall_s       = pins_sync[0];

  // ****************************************************************
  // speed command
  // ****************************************************************
  logic       speed_msb_q;
  logic       host_select_q;
  logic [8:0] speed_cmd_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      speed_msb_q   <= 1'b0;
      host_select_q <= 1'b0;
    end
    else if (wr_high)
    begin
      speed_msb_q   <= i_reg_wdata[`BIT_SPEED_COMMAND_MSB];
      host_select_q <= i_reg_wdata[`BIT_HOST_SPEED_SELECT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      speed_cmd_q <= `RESET_SPEED_COMMAND;
    else if (wr_low)
      speed_cmd_q <= {speed_msb_q, i_reg_wdata};
  end

  assign o_speed_command_value = speed_cmd_q;
  assign o_host_speed_select   = host_select_q;

  chk_msb_snapshot: assert property (
    wr_low |=> speed_cmd_q == {$past(speed_msb_q), $past(i_reg_wdata)})
    else $error("speed command not taken from msb snapshot");
  chk_high_no_effect: assert property (
    wr_high && !wr_low |=> $stable(speed_cmd_q))
    else $error("msb write changed speed command early");
  cov_speed: cover property (wr_high ##[1:4] wr_low);

  // ****************************************************************
  // unlock key sequence
  // ****************************************************************
  key_state_t key_state_q;
  logic [7:0] key_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      key_state_q <= KEY_IDLE;
      key_q       <= `RESET_BYTE;
    end
    else if (access)
    begin
      case (key_state_q)
        KEY_IDLE:
        begin
          key_q <= wr_key ? i_reg_wdata : `RESET_BYTE;
          if (wr_key && i_reg_wdata == `PROGRAM_UNLOCK_KEY)
            key_state_q <= KEY_ARMED;
        end
        KEY_ARMED:
        begin
          if (!(wr_key && i_reg_wdata == `PROGRAM_UNLOCK_KEY))
          begin
            key_state_q <= KEY_IDLE;
            key_q       <= `RESET_BYTE;
          end
        end
        default:
        begin
          key_state_q <= KEY_IDLE;
          key_q       <= `RESET_BYTE;
        end
      endcase
    end
  end

  chk_key_cleared: assert property (
    access && key_state_q == KEY_ARMED && !wr_key |=> key_q == `RESET_BYTE
      && key_state_q == KEY_IDLE)
    else $error("key not cleared after other access");

  // ****************************************************************
  // nvm and power control
  // ****************************************************************
  logic inhibit_q;
  logic cfg_unlock_q;
  logic reload_q;
  logic program_q;
  logic cfg_wr_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      inhibit_q    <= 1'b0;
      cfg_unlock_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      inhibit_q    <= i_reg_wdata[`BIT_LOW_POWER_INHIBIT];
      cfg_unlock_q <= i_reg_wdata[`BIT_CONFIG_WRITE_UNLOCK];
    end
  end

  // command pulses last one enabled cycle
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      reload_q  <= 1'b0;
      program_q <= 1'b0;
      cfg_wr_q  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      reload_q  <= wr_ctrl && i_reg_wdata[`BIT_NVM_RELOAD];
      program_q <= program_set && key_state_q == KEY_ARMED;
      cfg_wr_q  <= i_reg_wr && cfg_unlock_q && i_reg_addr >= `OFS_CONFIG_FIRST
                   && i_reg_addr <= `OFS_CONFIG_LAST;
    end
  end

  assign o_nvm_reload  = reload_q;
  assign o_nvm_program = program_q;
  assign o_config_wr   = cfg_wr_q;

  chk_program_needs_key: assert property (
    o_nvm_program |-> $past(key_state_q == KEY_ARMED && program_set))
    else $error("program pulse without armed key");
  chk_cfg_gate: assert property (
    o_config_wr |-> $past(cfg_unlock_q && i_reg_wr))
    else $error("configuration write while locked");
  cov_program: cover property (wr_key ##[1:4] program_set ##1 o_nvm_program);

  // ****************************************************************
  // low-power state
  // ****************************************************************
  logic low_power_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      low_power_q <= 1'b0;
    else if (i_clk_en)
    begin
      if (i_wake)
        low_power_q <= 1'b0;
      else if (i_sleep_request && !inhibit_q)
        low_power_q <= 1'b1;
    end
  end

  assign o_low_power_enter = low_power_q;

  chk_inhibit_sleep: assert property (
    inhibit_q && !low_power_q |=> !low_power_q)
    else $error("low power entered while inhibited");

  // ****************************************************************
  // sticky overcurrent flag
  // ****************************************************************
  logic overcurrent_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      overcurrent_q <= 1'b0;
    else if (i_clk_en)
    begin
      if (overcurrent_s)
        overcurrent_q <= 1'b1;
      else if (rd_status)
        overcurrent_q <= 1'b0;
    end
  end

  chk_overcurrent_sticky: assert property (
    (i_clk_en && overcurrent_s) || (overcurrent_q && !rd_status) |=> overcurrent_q)
    else $error("overcurrent flag not held");
  chk_status_clear: assert property (
    rd_status && !overcurrent_s |=> !overcurrent_q)
    else $error("overcurrent flag not cleared on read");
  cov_overcurrent: cover property (overcurrent_q ##1 rd_status ##1 !overcurrent_q);

  // ****************************************************************
  // rotor frequency coherent readout
  // ****************************************************************
  logic [7:0] freq_low_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      freq_low_q <= `RESET_BYTE;
    else if (rd_freq_high)
      freq_low_q <= i_rotor_frequency[7:0];
  end

  chk_freq_coherent: assert property (
    rd_freq_high |=> freq_low_q == $past(i_rotor_frequency[7:0]))
    else $error("low frequency byte not latched");
  cov_freq: cover property (rd_freq_high ##[1:4] (i_reg_rd && i_reg_addr == 8'h12));

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [7:0] status_byte;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic       rvalid_q;

  always_comb
  begin
    status_byte = `RESET_BYTE;
    status_byte[`BIT_THERMAL_FAULT]     = thermal_s;
    status_byte[`BIT_LOW_POWER_ACTIVE]  = low_power_q;
    status_byte[`BIT_PHASE_OVERCURRENT] = overcurrent_q || overcurrent_s;
    status_byte[`BIT_ROTOR_STALL]       = stall_s;
  end

  always_comb
  begin
    case (i_reg_addr)
      `OFS_SPEED_COMMAND_LOW:         rdata_d = speed_cmd_q[7:0];
      `OFS_SPEED_COMMAND_HIGH_SELECT: rdata_d = {host_select_q, 6'h00, speed_msb_q};
      `OFS_NVM_UNLOCK_KEY:            rdata_d = key_q;
      `OFS_NVM_AND_POWER_CONTROL:     rdata_d = {inhibit_q, cfg_unlock_q, 6'h00};
      `OFS_FAULT_STATUS:              rdata_d = status_byte;
      `OFS_ROTOR_FREQUENCY_HIGH:      rdata_d = i_rotor_frequency[15:8];
      `OFS_ROTOR_FREQUENCY_LOW:       rdata_d = freq_low_q;
      default:                        rdata_d = `RESET_BYTE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rdata_q  <= `RESET_BYTE;
      rvalid_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      rvalid_q <= i_reg_rd;
      if (i_reg_rd)
        rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata  = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  chk_read_latency: assert property (
    i_clk_en && i_reg_rd && hits(i_reg_addr, 8'h05) |=> o_reg_rvalid && o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");

endmodule

// ==== motor_regs_defs.svh ====
/*
  Register offsets, field positions, key value and reset values of the
  motor driver host register bank.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef MOTOR_REGS_DEFS_SVH
`define MOTOR_REGS_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_SPEED_COMMAND_LOW         8'h00
`define OFS_SPEED_COMMAND_HIGH_SELECT 8'h01
`define OFS_NVM_UNLOCK_KEY            8'h02
`define OFS_NVM_AND_POWER_CONTROL     8'h03
`define OFS_FAULT_STATUS              8'h10
`define OFS_ROTOR_FREQUENCY_HIGH      8'h11
`define OFS_ROTOR_FREQUENCY_LOW       8'h12
`define OFS_CONFIG_FIRST              8'h20
`define OFS_CONFIG_LAST               8'h2B

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_HOST_SPEED_SELECT   7
`define BIT_SPEED_COMMAND_MSB   0
`define BIT_LOW_POWER_INHIBIT   7
`define BIT_CONFIG_WRITE_UNLOCK 6
`define BIT_NVM_RELOAD          5
`define BIT_NVM_PROGRAM         4
`define BIT_THERMAL_FAULT       7
`define BIT_LOW_POWER_ACTIVE    6
`define BIT_PHASE_OVERCURRENT   5
`define BIT_ROTOR_STALL         4

// ****************************************************************
// values
// ****************************************************************
`define PROGRAM_UNLOCK_KEY      8'hB6
`define RESET_BYTE              8'h00
`define RESET_SPEED_COMMAND     9'h000
`define RESET_ROTOR_FREQUENCY   16'h0000
`define SYNC_WIDTH              3

`endif

// ==== motor_regs_pkg.sv ====
/*
  Types of the motor driver host register bank.
  Assumes motor_regs_defs.svh is on the include path.
*/
`include "motor_regs_defs.svh"

package motor_regs_pkg;

  // ****************************************************************
  // unlock key sequence state
  // ****************************************************************
  typedef enum logic [0:0] {
    KEY_IDLE  = 1'b0,
    KEY_ARMED = 1'b1
  } key_state_t;

  typedef logic [7:0] reg_byte_t;

  // decode of one register offset
  function automatic logic hits(input reg_byte_t addr, input reg_byte_t ofs);
    hits = (addr == ofs);
  endfunction

endpackage

// ==== pin_sync.sv ====
/*
  Two-flop synchroniser for a group of level inputs from pins.
  Assumes inputs are slow levels; the first stage feeds only the second.
*/
`timescale 1ns/1ns
`include "motor_regs_defs.svh"

module pin_sync
  import motor_regs_pkg::*;
(
  // clock and reset
  input  wire logic                   i_core_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_clk_en,
  // levels
  input  wire logic [`SYNC_WIDTH-1:0] i_async,
  output logic      [`SYNC_WIDTH-1:0] o_sync
);

  // ****************************************************************
  // one synchroniser per bit
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `SYNC_WIDTH; g++)
    begin : g_bit
      logic stage1_q;
      logic stage2_q;

      always_ff @(posedge i_core_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          stage1_q <= 1'b0;
          stage2_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
          stage1_q <= i_async[g];
          stage2_q <= stage1_q;
        end
      end

      assign o_sync[g] = stage2_q;
    end
  endgenerate

endmodule

// ==== reg_host_model.sv ====
/*
  Register host model standing in for the i2c front end of the bank.
  Assumes the bank samples strobes on the rising edge of i_core_clk.
*/
`timescale 1ns/1ns

module reg_host_model
(
  // clock
  input  wire logic       i_core_clk,
  // answer from the bank
  input  wire logic       i_reg_rvalid,
  input  wire logic [7:0] i_reg_rdata,
  // requests to the bank
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  initial
  begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 8'hFF;
    o_reg_wdata = 8'hFF;
  end

  // one strobe cycle; a released bus shows the inverse of its last value
  task automatic access(input logic is_wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_core_clk);
    o_reg_wr    <= is_wr;
    o_reg_rd    <= ~is_wr;
    o_reg_addr  <= addr;
    o_reg_wdata <= data;
    @(posedge i_core_clk);
    o_reg_wr    <= 1'b0;
    o_reg_rd    <= 1'b0;
    o_reg_addr  <= ~addr;
    o_reg_wdata <= ~data;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    access(1'b1, addr, data);
  endtask

  // answer is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] addr, output logic ok, output logic [7:0] data);
    access(1'b0, addr, 8'hC3);
    #1;
    ok   = i_reg_rvalid;
    data = i_reg_rdata;
  endtask
endmodule

// ==== motor_driver_host_registers_tb.sv ====
/*
  Self-checking bench of the motor driver host register bank.
  Assumes reg_host_model as requester and a 10 MHz clock.
*/
`timescale 1ns/1ns

module motor_driver_host_registers_tb;
  import motor_regs_pkg::*;

  logic        core_clk;
  logic        arst_n;
  logic        clk_en;
  logic        reg_wr;
  logic        reg_rd;
  logic  [7:0] reg_addr;
  logic  [7:0] reg_wdata;
  logic  [7:0] reg_rdata;
  logic        reg_rvalid;
  logic  [8:0] speed;
  logic        host_sel;
  logic        cfg_wr;
  logic        nvm_reload;
  logic        nvm_program;
  logic        sleep_req;
  logic        wake;
  logic        low_power;
  logic        thermal;
  logic        overcur;
  logic        stall;
  logic [15:0] rotor_freq;
  int          n_errors;
  int          n_checks;
  int          n_prog;
  int          n_reload;
  int          n_cfg;
  int          cycles;

  motor_driver_host_registers uut (
    .i_core_clk(core_clk), .i_arst_n(arst_n), .i_clk_en(clk_en),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
    .o_speed_command_value(speed), .o_host_speed_select(host_sel),
    .o_config_wr(cfg_wr), .o_nvm_reload(nvm_reload), .o_nvm_program(nvm_program),
    .i_sleep_request(sleep_req), .i_wake(wake), .o_low_power_enter(low_power),
    .i_thermal_fault(thermal), .i_phase_overcurrent(overcur),
    .i_rotor_stall(stall), .i_rotor_frequency(rotor_freq)
  );

  reg_host_model host (
    .i_core_clk(core_clk), .i_reg_rvalid(reg_rvalid), .i_reg_rdata(reg_rdata),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ****************************************************************
  // pulse counters and hang guard
  // ****************************************************************
  always @(posedge core_clk)
  begin
    if (nvm_program === 1'b1) n_prog++;
    if (nvm_reload === 1'b1) n_reload++;
    if (cfg_wr === 1'b1) n_cfg++;
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      complete_run();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic       ok;
    logic [7:0] d;
    host.rd(addr, ok, d);
    check({15'h0000, ok}, 16'h0001);
    check({8'h00, d}, {8'h00, exp});
  endtask

  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask

  task automatic complete_run();
    $display("errors=%0d checks=%0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    arst_n     = 1'b0;
    clk_en     = 1'b1;
    sleep_req  = 1'b0;
    wake       = 1'b0;
    thermal    = 1'b0;
    overcur    = 1'b0;
    stall      = 1'b0;
    rotor_freq = 16'h0000;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    settle();
    check({7'h00, speed}, 16'h0000);
    rchk(8'h03, 8'h00);
    // msb first, command moves only with the low byte
    host.wr(8'h01, 8'h81);
    settle();
    check({7'h00, speed}, 16'h0000);
    host.wr(8'h00, 8'h5A);
    settle();
    check({7'h00, speed}, 16'h015A);
    check({15'h0000, host_sel}, 16'h0001);
    rchk(8'h01, 8'h81);
    rchk(8'h00, 8'h5A);
    host.wr(8'h01, 8'h7E);
    rchk(8'h01, 8'h00);
    // frozen clock enable drops a write
    @(posedge core_clk) clk_en <= 1'b0;
    host.wr(8'h00, 8'h11);
    @(posedge core_clk) clk_en <= 1'b1;
    settle();
    check({7'h00, speed}, 16'h015A);
    // key sequence
    host.wr(8'h02, 8'hB6);
    host.wr(8'h03, 8'h10);
    settle();
    check(16'(n_prog), 16'h0001);
    host.wr(8'h03, 8'h10);
    settle();
    check(16'(n_prog), 16'h0001);
    host.wr(8'h02, 8'hB6);
    rchk(8'h00, 8'h5A);
    host.wr(8'h03, 8'h10);
    settle();
    check(16'(n_prog), 16'h0001);
    rchk(8'h02, 8'h00);
    // reload and configuration gate
    host.wr(8'h03, 8'h20);
    settle();
    check(16'(n_reload), 16'h0001);
    rchk(8'h03, 8'h00);
    host.wr(8'h21, 8'h55);
    settle();
    check(16'(n_cfg), 16'h0000);
    host.wr(8'h03, 8'h40);
    host.wr(8'h2B, 8'h55);
    settle();
    check(16'(n_cfg), 16'h0001);
    rchk(8'h03, 8'h40);
    // low power inhibit
    host.wr(8'h03, 8'h80);
    @(posedge core_clk) sleep_req <= 1'b1;
    repeat (4) settle();
    check({15'h0000, low_power}, 16'h0000);
    host.wr(8'h03, 8'h00);
    repeat (3) settle();
    check({15'h0000, low_power}, 16'h0001);
    rchk(8'h10, 8'h40);
    @(posedge core_clk) sleep_req <= 1'b0;
    wake <= 1'b1;
    repeat (3) @(posedge core_clk);
    wake <= 1'b0;
    // status pins and sticky overcurrent
    thermal <= 1'b1;
    stall   <= 1'b1;
    overcur <= 1'b1;
    repeat (3) @(posedge core_clk);
    overcur <= 1'b0;
    repeat (5) settle();
    rchk(8'h10, 8'hB0);
    rchk(8'h10, 8'h90);
    host.wr(8'h10, 8'hFF);
    rchk(8'h10, 8'h90);
    @(posedge core_clk) thermal <= 1'b0;
    stall <= 1'b0;
    repeat (5) settle();
    rchk(8'h10, 8'h00);
    // rotor frequency, high byte first
    @(posedge core_clk) rotor_freq <= 16'h01FF;
    settle();
    rchk(8'h11, 8'h01);
    @(posedge core_clk) rotor_freq <= 16'h0234;
    rchk(8'h12, 8'hFF);
    host.wr(8'h11, 8'hAA);
    rchk(8'h11, 8'h02);
    rchk(8'h05, 8'h00);
    complete_run();
  end
endmodule
